// File: src/umf_pkg.sv
/*
 * constants for the multidrop address filter block: register offsets,
 * field positions, reset values and cycle counts.
 * assumes a 32-bit axi4-lite register bus with byte addresses.
 */
package umf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CSA = 8'h04;
    localparam logic [7:0] OFS_CSB = 8'h08;
    localparam logic [7:0] OFS_SHARED = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    // ctrl_status_a fields
    localparam int CSA_RXC = 7;
    localparam int CSA_TXC = 6;
    localparam int CSA_AFE = 0;
    // ctrl_status_b fields
    localparam int CSB_SIZE2 = 2;
    localparam int CSB_RX9 = 1;
    localparam int CSB_TX9 = 0;
    // shared location fields
    localparam int SH_SEL = 7;
    localparam int FC_STOP = 3;
    localparam int FC_SIZE_LO = 1;
    // irq status bits
    localparam int IRQ_RX_STORE = 0;
    localparam int IRQ_RX_ADDR = 1;
    localparam int IRQ_TXC = 2;
    localparam int IRQ_DROP = 3;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [2:0] SIZE_RST = 3'h3;
    localparam logic [3:0] BAUD_HI_RST = 4'h0;
    localparam logic AFE_RST = 1'b0;
    // character size code for nine data bits
    localparam logic [2:0] SIZE_NINE = 3'h7;
    // window for the timed read of the shared location
    localparam logic [3:0] SEQ_WINDOW_CYCLES = 4'h8;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: src/umf_top.sv
/*
 * multidrop address filter for a serial receiver, the transmit frame
 * former, and the shared baud-high / frame-control location, behind an
 * axi4-lite slave.
 * assumes the bit-level receiver and transmitter sit on the same clock:
 * frames arrive as one-cycle pulses, completions return as pulses.
 */
// Summary of operation
// - filter on: data frames are dropped, never reach the receive buffer
// - transmit path ignores the filter enable entirely
// - five to eight bit characters: first stop bit is the frame type
// - nine bit characters: ninth bit is frame type, kept as rx_ninth_bit
// - frame type one means address frame, zero means data frame
// - filter on: address frames stored and flag set as usual
// - nine bit mode: tx_ninth_bit is sent as ninth data bit
// - one character size setting shared by transmit and receive
// - shared location write: bit 7 zero baud high, one frame control
// - shared read gives baud high, read right after gives frame control
// - transmit complete flag cleared by writing one or by irq ack
// - filter enable is bit 0 of ctrl_status_a, resets to zero
`timescale 1ns/1ns
`default_nettype none
module umf_top (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic rx_frame_valid_in,
    input wire logic [8:0] rx_frame_data_in,
    input wire logic rx_stop1_in,
    output logic tx_frame_valid_out,
    output logic [8:0] tx_frame_data_out,
    output logic [2:0] tx_char_size_out,
    output logic tx_stop_bits_out,
    input wire logic tx_done_in,
    input wire logic tx_irq_ack_in,
    output logic [3:0] baud_div_high_out,
    output logic irq_out
);
    logic addr_filter_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic rx_complete_flag;
    logic tx_complete_flag;
    logic stop_bits_sel;
    logic [2:0] char_size_sel;
    logic [3:0] baud_div_high;
    logic [7:0] rx_data;
    localparam int IRQ_W_L = umf_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_stat;
    logic [IRQ_W_L-1:0] irq_mask;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic seq_armed;
    logic [3:0] seq_cnt;

    // one write at a time: both halves held until applied
    wire logic do_write = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
    wire logic wr_lo = do_write && w_strb[0];
    wire logic ar_take = s_axi_arvalid_in && s_axi_arready_out;
    wire logic wr_data = wr_lo && aw_addr == umf_pkg::OFS_DATA;
    wire logic wr_csa = wr_lo && aw_addr == umf_pkg::OFS_CSA;
    wire logic wr_csb = wr_lo && aw_addr == umf_pkg::OFS_CSB;
    wire logic wr_sh = wr_lo && aw_addr == umf_pkg::OFS_SHARED;
    wire logic wr_stat = wr_lo && aw_addr == umf_pkg::OFS_IRQ_STAT;
    wire logic wr_mask = wr_lo && aw_addr == umf_pkg::OFS_IRQ_MASK;
    wire logic rd_data = ar_take && s_axi_araddr_in == umf_pkg::OFS_DATA;
    wire logic rd_sh = ar_take && s_axi_araddr_in == umf_pkg::OFS_SHARED;
    wire logic size_nine = char_size_sel == umf_pkg::SIZE_NINE;
    // unused high bits of short characters read and send as zero
    wire logic [7:0] size_mask = 8'hff >> (2'h3 - char_size_sel[1:0]);
    wire logic [7:0] frame_ctrl = {1'b1, 3'h0, stop_bits_sel, char_size_sel[1:0], 1'b0};

    wire logic frame_type = size_nine ? rx_frame_data_in[8] : rx_stop1_in;
    wire logic frame_is_addr = frame_type;
    // data frames dropped only while filtering
    wire logic rx_store = rx_frame_valid_in && (!addr_filter_enable || frame_is_addr);
    wire logic rx_drop = rx_frame_valid_in && !rx_store;

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == umf_pkg::OFS_DATA || a == umf_pkg::OFS_CSA || a == umf_pkg::OFS_CSB ||
                 a == umf_pkg::OFS_SHARED || a == umf_pkg::OFS_IRQ_STAT || a == umf_pkg::OFS_IRQ_MASK;
    endfunction

    // write address and data channels, taken in either order
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_addr <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end else if (do_write) begin
                s_axi_awready_out <= 1'b1;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end else if (do_write) begin
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // write response, error for unmapped offsets
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= umf_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= mapped(aw_addr) ? umf_pkg::RESP_OKAY : umf_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // timed read sequence; window keeps a stale first read from arming forever
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seq_armed <= 1'b0;
            seq_cnt <= 4'h0;
        end else if (rd_sh && !seq_armed) begin
            seq_armed <= 1'b1;
            seq_cnt <= 4'h0;
        end else if (ar_take || do_write || seq_cnt == umf_pkg::SEQ_WINDOW_CYCLES) begin
            seq_armed <= 1'b0;
        end else if (seq_armed) begin
            seq_cnt <= seq_cnt + 4'h1;
        end
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= umf_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= mapped(s_axi_araddr_in) ? umf_pkg::RESP_OKAY : umf_pkg::RESP_SLVERR;
            case (s_axi_araddr_in)
                umf_pkg::OFS_DATA: s_axi_rdata_out <= {24'h0, rx_data};
                umf_pkg::OFS_CSA: s_axi_rdata_out <= {24'h0, rx_complete_flag, tx_complete_flag, 5'h0, addr_filter_enable};
                umf_pkg::OFS_CSB: s_axi_rdata_out <= {29'h0, char_size_sel[2], rx_ninth_bit, tx_ninth_bit};
                // second read in the sequence sees frame control
                umf_pkg::OFS_SHARED: s_axi_rdata_out <= {24'h0, seq_armed ? frame_ctrl : {4'h0, baud_div_high}};
                umf_pkg::OFS_IRQ_STAT: s_axi_rdata_out <= {28'h0, irq_stat};
                umf_pkg::OFS_IRQ_MASK: s_axi_rdata_out <= {28'h0, irq_mask};
                default: s_axi_rdata_out <= 32'h0;
            endcase
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // filter enable at bit 0, cleared by reset
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_filter_enable <= umf_pkg::AFE_RST;
        end else if (wr_csa) begin
            addr_filter_enable <= w_data[umf_pkg::CSA_AFE];
        end
    end

    // bit 7 picks the destination of a shared write
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            baud_div_high <= umf_pkg::BAUD_HI_RST;
            stop_bits_sel <= 1'b0;
            char_size_sel <= umf_pkg::SIZE_RST;
            tx_ninth_bit <= 1'b0;
        end else begin
            if (wr_sh && !w_data[umf_pkg::SH_SEL]) begin
                baud_div_high <= w_data[3:0];
            end else if (wr_sh) begin
                stop_bits_sel <= w_data[umf_pkg::FC_STOP];
                char_size_sel[1:0] <= w_data[umf_pkg::FC_SIZE_LO +: 2];
            end
            if (wr_csb) begin
                char_size_sel[2] <= w_data[umf_pkg::CSB_SIZE2];
                tx_ninth_bit <= w_data[umf_pkg::CSB_TX9];
            end
        end
    end

    // receive buffer; a store in the cycle of a pop keeps the flag set
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_data <= 8'h00;
            rx_ninth_bit <= 1'b0;
            rx_complete_flag <= 1'b0;
        end else if (rx_store) begin
            rx_data <= rx_frame_data_in[7:0] & size_mask;
            rx_ninth_bit <= size_nine & rx_frame_data_in[8];
            rx_complete_flag <= 1'b1;
        end else if (rd_data) begin
            rx_complete_flag <= 1'b0;
        end
    end

    // transmit complete: set wins over write-one and irq ack
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_complete_flag <= 1'b0;
        end else if (tx_done_in) begin
            tx_complete_flag <= 1'b1;
        end else if (tx_irq_ack_in || (wr_csa && w_data[umf_pkg::CSA_TXC])) begin
            tx_complete_flag <= 1'b0;
        end
    end

    // transmit frame former, no filter term in it
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_frame_valid_out <= 1'b0;
            tx_frame_data_out <= 9'h000;
        end else begin
            tx_frame_valid_out <= wr_data;
            if (wr_data) begin
                tx_frame_data_out <= {size_nine & tx_ninth_bit, w_data[7:0] & size_mask};
            end
        end
    end

    // one size setting drives both directions
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_char_size_out <= umf_pkg::SIZE_RST;
            tx_stop_bits_out <= 1'b0;
            baud_div_high_out <= umf_pkg::BAUD_HI_RST;
        end else begin
            tx_char_size_out <= char_size_sel;
            tx_stop_bits_out <= stop_bits_sel;
            baud_div_high_out <= baud_div_high;
        end
    end

    // sticky event bits, write one to clear, new event wins
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq_out <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_stat ? w_data[IRQ_W_L-1:0] : '0)) |
                        {rx_drop, tx_done_in, rx_store && frame_is_addr, rx_store};
            if (wr_mask) begin
                irq_mask <= w_data[IRQ_W_L-1:0];
            end
            irq_out <= |(irq_stat & irq_mask);
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    // dropped frame leaves the buffer alone
    drop_data_a: assert property (rx_frame_valid_in && addr_filter_enable && !frame_type
        |=> rx_data == $past(rx_data) && rx_ninth_bit == $past(rx_ninth_bit))
        else $error("data frame reached the buffer under filtering");
    keep_addr_a: assert property (rx_frame_valid_in && frame_type
        |=> rx_complete_flag && rx_data == ($past(rx_frame_data_in[7:0]) & $past(size_mask)))
        else $error("address frame not stored");
    filter_off_a: assert property (rx_frame_valid_in && !addr_filter_enable
        |=> rx_complete_flag && rx_data == ($past(rx_frame_data_in[7:0]) & $past(size_mask)))
        else $error("frame lost with filter off");
    // stop bit decides for short characters
    stop_type_a: assert property (rx_frame_valid_in && addr_filter_enable && !size_nine
        |-> rx_store == rx_stop1_in)
        else $error("short frame type not taken from stop bit");
    // ninth bit decides and is kept
    ninth_type_a: assert property (rx_frame_valid_in && size_nine && addr_filter_enable
        |-> rx_store == rx_frame_data_in[8] ##1 (!$past(rx_store) || rx_ninth_bit))
        else $error("ninth bit frame type wrong");
    tx_ninth_a: assert property (wr_data |=> tx_frame_valid_out &&
        tx_frame_data_out[8] == ($past(size_nine) & $past(tx_ninth_bit)))
        else $error("ninth transmit bit wrong");
    shared_wr_a: assert property (wr_sh && !w_data[umf_pkg::SH_SEL]
        |=> baud_div_high == $past(w_data[3:0]) && $stable(stop_bits_sel) ##1
        baud_div_high_out == $past(baud_div_high))
        else $error("shared write went to the wrong register");
    // first read returns baud high and arms the timed sequence
    shared_rd_a: assert property (rd_sh && !seq_armed ##1 s_axi_rvalid_out
        |-> s_axi_rdata_out[7:0] == {4'h0, $past(baud_div_high)} && seq_armed)
        else $error("first shared read did not return baud high");
    // ack clears the transmit complete flag
    txc_clear_a: assert property (tx_complete_flag && tx_irq_ack_in && !tx_done_in
        |=> !tx_complete_flag)
        else $error("transmit complete flag not cleared");
    // transmit size mirrors the shared setting
    size_share_a: assert property (##1 tx_char_size_out == $past(char_size_sel))
        else $error("transmit size differs from receive size");
    irq_level_a: assert property (##1 irq_out == |($past(irq_stat) & $past(irq_mask)))
        else $error("interrupt level wrong");

    addr_kept_c: cover property (rx_frame_valid_in && addr_filter_enable && frame_type);
    data_drop_c: cover property (rx_drop);
    seq_read_c: cover property (rd_sh && seq_armed);
    irq_c: cover property (irq_out);
endmodule
`default_nettype wire

// File: testbench/umf_far_node.sv
/*
 * far node model on the frame link: drives received frames into the
 * filter and answers each transmitted frame with a completion pulse.
 * assumes the same clock as the block; frames are whole-word pulses.
 */
`timescale 1ns/1ns
`default_nettype none
module umf_far_node (
    input wire logic sys_clk_in,
    output logic rx_frame_valid_out,
    output logic [8:0] rx_frame_data_out,
    output logic rx_stop1_out,
    input wire logic tx_frame_valid_in,
    input wire logic [8:0] tx_frame_data_in,
    output logic tx_done_out
);
    int lat = 4; // completion delay, raised by the bench for slow answers
    int n_tx = 0;
    int cnt = 0;
    logic [8:0] last_tx = 9'h000;
    // idle link levels at time zero
    initial begin
        rx_frame_valid_out = 1'b0;
        rx_frame_data_out = 9'h000;
        rx_stop1_out = 1'b1;
        tx_done_out = 1'b0;
    end
    // sender uses two stop bits, first carries type
    task automatic send(input logic [8:0] d, input logic stop1);
        rx_frame_data_out <= d;
        rx_stop1_out <= stop1;
        rx_frame_valid_out <= 1'b1;
        @(posedge sys_clk_in);
        rx_frame_valid_out <= 1'b0;
        // stale lines inverted so an old frame cannot pass for a new one
        rx_frame_data_out <= ~d;
        rx_stop1_out <= ~stop1;
        @(posedge sys_clk_in);
    endtask
    // capture each frame, report completion lat cycles later
    always @(posedge sys_clk_in) begin
        tx_done_out <= 1'b0;
        if (tx_frame_valid_in) begin
            last_tx <= tx_frame_data_in;
            n_tx <= n_tx + 1;
            cnt <= lat;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            tx_done_out <= (cnt == 1);
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
/*
 * self-checking bench for umf_top: axi4-lite register tasks, the far node
 * model on the frame link, and access sequences with expected values.
 * assumes umf_pkg and umf_far_node are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, tx_ack = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_stop1, tx_valid, tx_done, tx_stop, irq;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata, rd_val;
    logic [8:0] rx_data, tx_data;
    logic [2:0] tx_size;
    logic [3:0] baud_hi;
    int miscompares = 0;
    int n_compared = 0;

    always #4 sys_clk = ~sys_clk;

    umf_top dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .rx_frame_valid_in(rx_valid), .rx_frame_data_in(rx_data),
        .rx_stop1_in(rx_stop1), .tx_frame_valid_out(tx_valid), .tx_frame_data_out(tx_data),
        .tx_char_size_out(tx_size), .tx_stop_bits_out(tx_stop), .tx_done_in(tx_done),
        .tx_irq_ack_in(tx_ack), .baud_div_high_out(baud_hi), .irq_out(irq));
    umf_far_node far (.sys_clk_in(sys_clk), .rx_frame_valid_out(rx_valid), .rx_frame_data_out(rx_data),
        .rx_stop1_out(rx_stop1), .tx_frame_valid_in(tx_valid), .tx_frame_data_in(tx_data),
        .tx_done_out(tx_done));

    // write: both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic aw_ok;
        logic w_ok;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        last_resp = bresp;
        bready <= 1'b0;
        // one idle edge so the next call never reassigns in this step
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rd_val = rdata;
        last_resp = rresp;
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_val, exp);
    endtask
    // send one word and check the frame the far node saw
    task automatic send_tx(input logic [31:0] d, input logic [8:0] exp);
        int k;
        k = far.n_tx;
        wr(umf_pkg::OFS_DATA, d);
        for (int i = 0; i < 50 && far.n_tx == k; i++) @(posedge sys_clk);
        // exactly one new frame, so a stale capture cannot pass
        chk(far.n_tx - k, 32'h1);
        chk({23'h0, far.last_tx}, {23'h0, exp});
        repeat (far.lat + 3) @(posedge sys_clk);
    endtask
    task automatic done_test(input string s);
        $display("test %s ended, mismatches so far %0d", s, miscompares);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd_chk(umf_pkg::OFS_CSA, 32'h0);
        rd_chk(umf_pkg::OFS_SHARED, 32'h0);
        chk({29'h0, tx_size}, 32'h3);
        rd(8'h18);
        chk({30'h0, last_resp}, {30'h0, umf_pkg::RESP_SLVERR});
        wr(8'h18, 32'hff);
        chk({30'h0, last_resp}, {30'h0, umf_pkg::RESP_SLVERR});
        done_test("reset");
        far.send(9'h1a5, 1'b0);
        rd_chk(umf_pkg::OFS_CSA, 32'h80);
        rd_chk(umf_pkg::OFS_IRQ_STAT, 32'h1);
        rd_chk(umf_pkg::OFS_DATA, 32'ha5);
        far.send(9'h03c, 1'b1);
        rd_chk(umf_pkg::OFS_IRQ_STAT, 32'h3);
        rd_chk(umf_pkg::OFS_DATA, 32'h3c);
        wr(umf_pkg::OFS_IRQ_STAT, 32'hf);
        done_test("filter off");
        wr(umf_pkg::OFS_CSA, 32'h1, 4'h0);
        rd_chk(umf_pkg::OFS_CSA, 32'h0);
        wr(umf_pkg::OFS_CSA, 32'h1);
        rd_chk(umf_pkg::OFS_CSA, 32'h1);
        far.send(9'h133, 1'b0);
        rd_chk(umf_pkg::OFS_CSA, 32'h1);
        rd_chk(umf_pkg::OFS_IRQ_STAT, 32'h8);
        far.send(9'h042, 1'b1);
        rd_chk(umf_pkg::OFS_CSA, 32'h81);
        rd_chk(umf_pkg::OFS_IRQ_STAT, 32'hb);
        rd_chk(umf_pkg::OFS_DATA, 32'h42);
        wr(umf_pkg::OFS_CSA, 32'h0);
        far.send(9'h077, 1'b0);
        rd_chk(umf_pkg::OFS_DATA, 32'h77);
        wr(umf_pkg::OFS_CSA, 32'h1);
        far.send(9'h078, 1'b0);
        rd_chk(umf_pkg::OFS_CSA, 32'h1);
        done_test("filter on");
        wr(umf_pkg::OFS_SHARED, 32'h05);
        wr(umf_pkg::OFS_SHARED, 32'h8e);
        chk({28'h0, baud_hi}, 32'h5);
        chk({31'h0, tx_stop}, 32'h1);
        rd_chk(umf_pkg::OFS_SHARED, 32'h5);
        rd_chk(umf_pkg::OFS_SHARED, 32'h8e);
        rd_chk(umf_pkg::OFS_CSA, 32'h1);
        rd_chk(umf_pkg::OFS_SHARED, 32'h5);
        done_test("shared");
        wr(umf_pkg::OFS_CSB, 32'h4);
        chk({29'h0, tx_size}, {29'h0, umf_pkg::SIZE_NINE});
        far.send(9'h1c3, 1'b0);
        rd_chk(umf_pkg::OFS_CSB, 32'h6);
        rd_chk(umf_pkg::OFS_DATA, 32'hc3);
        far.send(9'h0d4, 1'b1);
        rd_chk(umf_pkg::OFS_CSA, 32'h1);
        wr(umf_pkg::OFS_CSB, 32'h5);
        send_tx(32'h55, 9'h155);
        wr(umf_pkg::OFS_CSA, 32'h0);
        send_tx(32'h55, 9'h155);
        wr(umf_pkg::OFS_CSB, 32'h4);
        send_tx(32'haa, 9'h0aa);
        wr(umf_pkg::OFS_CSB, 32'h1);
        send_tx(32'h5a, 9'h05a);
        done_test("nine bit");
        wr(umf_pkg::OFS_CSA, 32'h40);
        wr(umf_pkg::OFS_IRQ_STAT, 32'hf);
        wr(umf_pkg::OFS_IRQ_MASK, 32'h4);
        chk({31'h0, irq}, 32'h0);
        far.lat = 20;
        send_tx(32'h11, 9'h011);
        rd_chk(umf_pkg::OFS_CSA, 32'h40);
        chk({31'h0, irq}, 32'h1);
        wr(umf_pkg::OFS_CSA, 32'h40);
        rd_chk(umf_pkg::OFS_CSA, 32'h0);
        wr(umf_pkg::OFS_IRQ_STAT, 32'h4);
        chk({31'h0, irq}, 32'h0);
        far.lat = 2;
        send_tx(32'h12, 9'h012);
        tx_ack <= 1'b1;
        @(posedge sys_clk);
        tx_ack <= 1'b0;
        rd_chk(umf_pkg::OFS_CSA, 32'h0);
        wr(umf_pkg::OFS_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd_chk(umf_pkg::OFS_IRQ_STAT, 32'h4);
        done_test("tx complete");
        tally_and_finish();
    end
endmodule
`default_nettype wire
